// ### uncore_event_pkg.sv
// constants and carrier types for the uncore event selector
// assumes event sources deliver one-cycle pulses or per-cycle levels on mclk_i
// Operation
// - event 30H counts cancel requests: mask 04H channel 2, 07H any channel
// - event 31H counts priority updates: 01H/02H/04H channel 0/1/2, 07H any
// - priority update raised on isochronous high/critical hit of issued normal request
// - event 33H mask 04H counts force-ack conflict messages to local home
// - event 40H counts single-flit channel stall cycles; 01H-20H pick channel and link
// - event 40H mask 07H link 0, 38H link 1 any single-flit stall
// - stall cycles count even when another channel wins arbitration
// - event 41H counts multi-flit stall cycles per channel and link by mask 01H-10H; link 1 ncs is not selectable
package uncore_event_pkg;
  localparam int EVT_W = 8;
  localparam int MASK_W = 8;
  localparam int CNT_W_DEF = 48;
  localparam int CH_N = 3;

  localparam logic [EVT_W-1:0] EVT_CANCEL = 8'h30;
  localparam logic [EVT_W-1:0] EVT_PRIO_UPDATE = 8'h31;
  localparam logic [EVT_W-1:0] EVT_FRC_ACK = 8'h33;
  localparam logic [EVT_W-1:0] EVT_SINGLE_STALL = 8'h40;
  localparam logic [EVT_W-1:0] EVT_MULTI_STALL = 8'h41;

  localparam logic [MASK_W-1:0] MASK_CH0 = 8'h01;
  localparam logic [MASK_W-1:0] MASK_CH1 = 8'h02;
  localparam logic [MASK_W-1:0] MASK_CH2 = 8'h04;
  localparam logic [MASK_W-1:0] MASK_ANY = 8'h07;
  localparam logic [MASK_W-1:0] MASK_LOCAL = 8'h04;
  localparam logic [MASK_W-1:0] MASK_L1_B0 = 8'h08;
  localparam logic [MASK_W-1:0] MASK_L1_B1 = 8'h10;
  localparam logic [MASK_W-1:0] MASK_L1_B2 = 8'h20;
  localparam logic [MASK_W-1:0] MASK_LINK0 = 8'h07;
  localparam logic [MASK_W-1:0] MASK_LINK1 = 8'h38;

  // per-link single-flit stall levels
  typedef struct packed {
    logic home;
    logic snoop;
    logic non_data_response_channel;
  } single_stall_t;

  // per-link multi-flit stall levels; link 1 ncs is not selectable here
  typedef struct packed {
    logic data_response_channel;
    logic non_coherent_bypass_channel;
    logic non_coherent_standard_channel;
  } multi_stall_t;

  // home-logic request seen this cycle, used to raise priority updates
  typedef struct packed {
    logic valid;
    logic isochronous_request;
    logic [1:0] channel;
    logic match_normal_issued;
  } home_req_t;

  typedef struct packed {
    logic [EVT_W-1:0] event_code;
    logic [MASK_W-1:0] unit_mask;
  } select_t;
endpackage

// ### uncore_event_selector.sv
// event decode and counter for uncore performance monitoring
// assumes all inputs synchronous to mclk_i; software holds select stable while counting
`timescale 1ns/1ps
module uncore_event_selector #(
  parameter int CNT_W = uncore_event_pkg::CNT_W_DEF
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // software control
  input wire uncore_event_pkg::select_t select_i,
  input wire logic count_enable_i,
  input wire logic count_clear_i,
  // memory controller events, one-cycle pulses per channel
  input wire logic [uncore_event_pkg::CH_N-1:0] memory_cancel_event_i,
  input wire logic [uncore_event_pkg::CH_N-1:0] memory_priority_update_event_i,
  // home logic
  input wire uncore_event_pkg::home_req_t home_req_i,
  input wire logic force_ack_conflict_event_i,
  // link stall levels
  input wire uncore_event_pkg::single_stall_t single_stall_link0_i,
  input wire uncore_event_pkg::single_stall_t single_stall_link1_i,
  input wire uncore_event_pkg::multi_stall_t multi_stall_link0_i,
  input wire uncore_event_pkg::multi_stall_t multi_stall_link1_i,
  // results
  output logic [CNT_W-1:0] count_o,
  output logic select_valid_o,
  output logic priority_update_o,
  output logic [uncore_event_pkg::CH_N-1:0] priority_update_ch_o
);
  import uncore_event_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic prio_reg;
  logic [CH_N-1:0] prio_ch_reg;
  logic [CH_N-1:0] prio_ch_next;
  logic valid_reg;

  // selection fields
  wire [EVT_W-1:0] evt = select_i.event_code;
  wire [MASK_W-1:0] msk = select_i.unit_mask;

  // flattened stall widths and the channel 2 bit position
  localparam int SINGLE_N = 2 * $bits(single_stall_t);
  localparam int MULTI_N = 5;
  localparam int CH2_IDX = 2;

  // event code decode
  wire evt_cancel = (evt == EVT_CANCEL);
  wire evt_prio = (evt == EVT_PRIO_UPDATE);
  wire evt_frc = (evt == EVT_FRC_ACK);
  wire evt_single = (evt == EVT_SINGLE_STALL);
  wire evt_multi = (evt == EVT_MULTI_STALL);

  // unit mask decode; only exact encodings match, so mixed masks hold the count
  wire msk_ch0 = (msk == MASK_CH0);
  wire msk_ch1 = (msk == MASK_CH1);
  wire msk_ch2 = (msk == MASK_CH2);
  wire msk_any = (msk == MASK_ANY);
  wire msk_local = (msk == MASK_LOCAL);
  wire msk_l1_b0 = (msk == MASK_L1_B0);
  wire msk_l1_b1 = (msk == MASK_L1_B1);
  wire msk_l1_b2 = (msk == MASK_L1_B2);
  wire msk_link0 = (msk == MASK_LINK0);
  wire msk_link1 = (msk == MASK_LINK1);
  wire msk_one_ch = msk_ch0 | msk_ch1 | msk_ch2;
  wire msk_one_l1 = msk_l1_b0 | msk_l1_b1 | msk_l1_b2;

  // priority update from home logic: isochronous hit on an issued normal request
  wire prio_raise = home_req_i.valid & home_req_i.isochronous_request
    & home_req_i.match_normal_issued;
  always_comb begin
    prio_ch_next = '0;
    if (prio_raise && home_req_i.channel < 2'(CH_N)) begin
      prio_ch_next[home_req_i.channel] = 1'b1;
    end
  end

  // internal updates merged with those reported by the controller
  wire [CH_N-1:0] prio_evt = memory_priority_update_event_i | prio_ch_next;

  // cancel: channel 2 and any
  wire hit_cancel_ch2 = evt_cancel & msk_ch2;
  wire hit_cancel_any = evt_cancel & msk_any;
  wire cancel_ch2 = memory_cancel_event_i[CH2_IDX];
  wire cancel_any = |memory_cancel_event_i;
  wire inc_cancel_ch2 = hit_cancel_ch2 & cancel_ch2;
  wire inc_cancel_any = hit_cancel_any & cancel_any;
  wire inc_cancel = inc_cancel_ch2 | inc_cancel_any;

  // priority updates per channel and any
  wire hit_prio = evt_prio & (msk_one_ch | msk_any);
  wire [CH_N-1:0] prio_sel = prio_evt & msk[CH_N-1:0];
  wire inc_prio = hit_prio & (|prio_sel);

  // force-ack conflicts to local home
  wire hit_frc = evt_frc & msk_local;
  wire inc_frc = hit_frc & force_ack_conflict_event_i;

  // single-flit stalls; raw stall levels, no arbitration qualifier
  wire [SINGLE_N-1:0] single_vec = {single_stall_link1_i.non_data_response_channel,
    single_stall_link1_i.snoop, single_stall_link1_i.home,
    single_stall_link0_i.non_data_response_channel,
    single_stall_link0_i.snoop, single_stall_link0_i.home};
  wire single_one = msk_one_ch | msk_one_l1;
  wire single_grp = msk_link0 | msk_link1;
  wire hit_single = evt_single & (single_one | single_grp);
  wire [SINGLE_N-1:0] single_sel = single_vec & msk[SINGLE_N-1:0];
  wire inc_single = hit_single & (|single_sel);

  // multi-flit stalls; link 1 ncs lies outside the counted set
  wire [MULTI_N-1:0] multi_vec = {multi_stall_link1_i.non_coherent_bypass_channel,
    multi_stall_link1_i.data_response_channel,
    multi_stall_link0_i.non_coherent_standard_channel,
    multi_stall_link0_i.non_coherent_bypass_channel,
    multi_stall_link0_i.data_response_channel};
  wire hit_multi = evt_multi & (msk_one_ch | msk_l1_b0 | msk_l1_b1);
  wire [MULTI_N-1:0] multi_sel = multi_vec & msk[MULTI_N-1:0];
  wire inc_multi = hit_multi & (|multi_sel);

  wire sel_ok = hit_cancel_ch2 | hit_cancel_any | hit_prio | hit_frc
    | hit_single | hit_multi;
  wire inc = count_enable_i & (inc_cancel | inc_prio | inc_frc | inc_single
    | inc_multi);

  // clear wins only against stale counts; an event in the clear cycle counts as one
  always_comb begin
    if (count_clear_i) begin
      count_next = inc ? CNT_W'(1) : '0;
    end else if (inc) begin
      count_next = count_reg + CNT_W'(1);
    end else begin
      count_next = count_reg;
    end
  end

  // event counter
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // priority update pulse
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prio_reg <= 1'b0;
    end else begin
      prio_reg <= prio_raise;
    end
  end

  // one-hot channel of the update; channel 3 gives the pulse alone
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prio_ch_reg <= '0;
    end else begin
      prio_ch_reg <= prio_ch_next;
    end
  end

  // defined-selection flag, one cycle behind the select
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= sel_ok;
    end
  end

  assign count_o = count_reg;
  assign select_valid_o = valid_reg;
  assign priority_update_o = prio_reg;
  assign priority_update_ch_o = prio_ch_reg;
endmodule

// ### uncore_event_selector_asserts.sv
// port assertions for the event selector
// assumes bind onto uncore_event_selector, one clock domain
`timescale 1ns/1ps
module uncore_event_selector_asserts #(parameter int CNT_W = 48) (
  input wire logic mclk_i, rst_i, count_enable_i, count_clear_i, select_valid_o,
  input wire uncore_event_pkg::select_t select_i,
  input wire logic [2:0] memory_cancel_event_i, memory_priority_update_event_i,
  input wire uncore_event_pkg::home_req_t home_req_i,
  input wire logic force_ack_conflict_event_i, priority_update_o,
  input wire logic [2:0] priority_update_ch_o,
  input wire uncore_event_pkg::single_stall_t single_stall_link0_i, single_stall_link1_i,
  input wire uncore_event_pkg::multi_stall_t multi_stall_link1_i,
  input wire logic [CNT_W-1:0] count_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [CNT_W-1:0] prev_reg;
  wire logic [15:0] sel = select_i;
  wire logic inc = count_enable_i & !count_clear_i;
  wire logic bumped = count_o == prev_reg + 1'b1;
  always_ff @(posedge mclk_i) prev_reg <= count_o;
  chk_cancel_ch2: assert property (sel == 16'h3004 && inc && memory_cancel_event_i[2] |=> bumped)
    else $error("cancel on channel 2 not counted");
  chk_prio_any: assert property (sel == 16'h3107 && inc && |memory_priority_update_event_i |=> bumped)
    else $error("priority update not counted");
  chk_prio_raise: assert property (home_req_i == 5'h1B |=> priority_update_o && priority_update_ch_o == 3'h2)
    else $error("priority update not raised");
  chk_force_ack: assert property (sel == 16'h3304 && inc && force_ack_conflict_event_i |=> bumped)
    else $error("force ack conflict not counted");
  chk_stall_ndr1: assert property (sel == 16'h4020 && inc && single_stall_link1_i[0] |=> bumped)
    else $error("link 1 response stall not counted");
  chk_stall_link0: assert property (sel == 16'h4007 && inc && |single_stall_link0_i |=> bumped)
    else $error("link 0 stall not counted");
  chk_multi_ncb1: assert property (sel == 16'h4110 && inc && multi_stall_link1_i[1] |=> bumped)
    else $error("link 1 bypass stall not counted");
  chk_hold_undef: assert property (sel == 16'h3001 && !count_clear_i |=> count_o == prev_reg && !select_valid_o)
    else $error("undefined selection changed count");
endmodule
bind uncore_event_selector uncore_event_selector_asserts #(.CNT_W(CNT_W)) chk_u (.*);

// ### uncore_event_selector_tb_top.sv
// self-checking bench for the event selector
// assumes the design package is compiled first
`timescale 1ns/1ps
module uncore_event_selector_tb_top;
  import uncore_event_pkg::*;
  logic mclk_i = 0, rst_i = 1, en = 0, clr = 0, fa = 0, select_valid_o, priority_update_o;
  logic [2:0] can = 0, pri = 0, priority_update_ch_o;
  select_t sel = 0;
  home_req_t hr = 0;
  single_stall_t s0 = 0, s1 = 0;
  multi_stall_t m0 = 0, m1 = 0;
  logic [47:0] count_o, exp_cnt = 0;
  logic [4:0] exp_flags = 0;
  int failures = 0, comparisons = 0, cyc = 0;
  // row: select, expected increment, {disable, clear, home, cancel, prio, force, stalls}
  logic [47:0] tbl[31] = '{
    48'h3004_1_0040000, 48'h3004_0_0010000, 48'h3007_1_0030000,
    48'h3007_0_2010000, 48'h3007_1_1010000, 48'h3001_0_0010000, 48'h3302_0_0001000,
    48'h3101_1_0002000, 48'h3102_1_0004000, 48'h3104_1_0008000, 48'h3104_0_0002000,
    48'h3107_1_000C000, 48'h3102_1_0D80000, 48'h3102_0_0D00000, 48'h3304_1_0001000,
    48'h4001_1_0000800, 48'h4002_1_0000400, 48'h4004_1_0000200, 48'h4008_1_0000100,
    48'h4010_1_0000080, 48'h4020_1_0000040, 48'h4001_0_0000100,
    48'h4007_1_0000E00, 48'h4038_0_0000E00, 48'h4038_1_00000C0,
    48'h4101_1_0000020, 48'h4102_1_0000010, 48'h4104_1_0000008,
    48'h4108_1_0000004, 48'h4110_1_0000002, 48'h4110_0_0000004};
  uncore_event_selector dut_u (.mclk_i, .rst_i, .select_i(sel), .count_enable_i(en),
    .count_clear_i(clr), .memory_cancel_event_i(can), .memory_priority_update_event_i(pri),
    .home_req_i(hr), .force_ack_conflict_event_i(fa), .single_stall_link0_i(s0),
    .single_stall_link1_i(s1), .multi_stall_link0_i(m0), .multi_stall_link1_i(m1),
    .count_o, .select_valid_o, .priority_update_o, .priority_update_ch_o);
  task automatic cmp(input logic [47:0] got, want);
    comparisons++;
    if (got !== want) begin
      failures++;
      $display("[FAIL] %0t count %0h expected %0h", $time, got, want);
    end
  endtask
  task automatic cmp_flag(input logic [4:0] got, want);
    comparisons++;
    if (got !== want) begin
      failures++;
      $display("[FAIL] %0t flags %0h expected %0h", $time, got, want);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one stimulus cycle, then the count is checked once it has settled
  task automatic ev(input logic [47:0] e);
    @(negedge mclk_i);
    sel = e[47:32];
    {en, clr, hr, can, pri, fa, s0, s1, m0, m1} = {~e[25], e[24:0]};
    @(negedge mclk_i);
    exp_cnt = (e[24] ? 48'h0 : exp_cnt) + e[31:28];
    exp_flags = {sel != 16'h3001 && sel != 16'h3302, e[23] & e[22] & e[19],
      (e[23] & e[22] & e[19] && e[21:20] != 2'h3) ? 3'h1 << e[21:20] : 3'h0};
    {clr, hr, can, pri, fa, s0, s1, m0, m1} = 25'h0;
    cmp(count_o, exp_cnt);
    cmp_flag({select_valid_o, priority_update_o, priority_update_ch_o}, exp_flags);
  endtask
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      failures++;
      end_of_test;
    end
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 0;
    cmp(count_o, 48'h0);
    foreach (tbl[i]) ev(tbl[i]);
    end_of_test;
  end
endmodule
